/* File: hdl/awmc_core.sv */
// What this block does
// - Even start address stored as value minus one
// - Odd length flagged and reduced by one
// - Playback outputs samples of start/length region
// - Sample values limited to -8191..8191
// - Addresses 1..4,000,000 accepted, others rejected
// - 8191 positive peak, 0 offset, -8191 negative
// - Marker enable, address, length inside region
// - Marker high while playback inside marker span
// - Marker length limited to 4000 samples
// - Start or length change switches playback region
// - Single sample written at current edit address
// - Line fill interpolates between two endpoints
// - Builtin fill length minimum and divisibility enforced
// - Scale 100 percent is full range; too high rejected
// - Noise fill adds to or overwrites samples
// - Copy duplicates samples from source to destination
// - Clear zeroes a span or whole memory
// - One protected segment or whole memory read-only
// - Unprotect removes all write protection
// - Operations run only after yes; no abandons
// - Square duty 20-80 to 10MHz, 40-60 to 30MHz
// - Triangle symmetry 10-90, frequency at most 5MHz
`timescale 1ns/1ps
`default_nettype none
module awmc_core (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [21:0] startValue,
	input wire logic startWrite,
	input wire logic [21:0] lengthValue,
	input wire logic lengthWrite,
	output logic [21:0] playStart,
	output logic [21:0] playLength,
	output logic evenLengthNotice,
	output logic regionReject,
	input wire logic markEnable,
	input wire logic [21:0] markAddrValue,
	input wire logic [21:0] markLengthValue,
	input wire logic markWrite,
	output logic markReject,
	input wire logic [21:0] currentEditAddress,
	input wire logic signed [13:0] pointData,
	input wire logic pointWrite,
	output logic pointReject,
	input wire logic [1:0] opKind,
	input wire logic [21:0] opFrom,
	input wire logic [21:0] opTo,
	input wire logic [21:0] opLength,
	input wire logic opAll,
	input wire logic signed [13:0] fromData,
	input wire logic signed [13:0] toData,
	input wire logic executeConfirm,
	input wire logic confirmYes,
	input wire logic confirmNo,
	output logic opReject,
	output logic awaitingConfirm,
	output logic busy,
	input wire logic [1:0] builtinShape,
	input wire logic [21:0] fillLengthValue,
	input wire logic fillLengthWrite,
	output logic [21:0] fillLength,
	output logic fillLengthReject,
	input wire logic [6:0] scaleValue,
	input wire logic scaleWrite,
	output logic scaleTooHigh,
	input wire logic noiseAdd,
	input wire logic [21:0] protFrom,
	input wire logic [21:0] protTo,
	input wire logic protAll,
	input wire logic writeProtectSet,
	input wire logic unprotect,
	output logic writeProtectActive,
	input wire logic [1:0] waveSel,
	input wire logic [24:0] freqValue,
	input wire logic freqWrite,
	input wire logic [6:0] shapeParamValue,
	input wire logic shapeParamWrite,
	output logic [24:0] waveFreq,
	output logic [6:0] squareWaveDuty,
	output logic [6:0] triangleSymmetry,
	output logic settingReject,
	output logic signed [13:0] sampleData,
	output logic sampleMarker,
	output logic sampleValid,
	input wire logic sampleReady
);
	logic signed [13:0] mem [0:4000000];
	awmc_pkg::awmc_eng_t engState;
	logic [1:0] engOp;
	logic [1:0] engShape;
	logic engNoiseAdd;
	logic [21:0] engAddr, engFirst, engLast, engSrc, engPhase;
	logic signed [13:0] engBase, engEnd;
	logic [13:0] engAmp;
	logic [15:0] lfsr;
	logic [21:0] protLo, protHi;
	logic [21:0] markAddr, markLen;
	logic [6:0] scale;
	logic [21:0] playAddr;
	logic signed [13:0] bufData [0:1];
	logic bufMark [0:1];
	logic bufWrPtr, bufRdPtr;
	logic [1:0] bufCount;

	// Shared combinational terms
	logic restart, startOk;
	logic [21:0] regionLast;
	logic markHit;
	logic memWe;
	logic [21:0] memWa;
	logic signed [13:0] memWd;
	logic signed [13:0] engValue;
	logic [13:0] reqAmp;
	logic [21:0] evenLen;
	logic [21:0] oddStart;
	logic bufPush, bufPop;

	function automatic logic inRange(input logic [21:0] a);
		inRange = (a >= awmc_pkg::ADDR_FIRST) && (a <= awmc_pkg::ADDR_LAST);
	endfunction

	function automatic logic [13:0] absVal(input logic signed [13:0] v);
		absVal = v[13] ? 14'(-v) : 14'(v);
	endfunction

	// Odd start, even length
	assign oddStart = startValue[0] ? startValue : startValue - 22'h000001;
	assign evenLen = lengthValue[0] ? lengthValue - 22'h000001 : lengthValue;
	assign regionLast = playStart + playLength - 22'h000001;
	assign restart = startWrite | lengthWrite;
	// Sums in 23 bits so a region past the end cannot wrap into range
	assign startOk = inRange(oddStart) && (23'(oddStart) + 23'(playLength) <= 23'(awmc_pkg::ADDR_LAST) + 23'h000001);
	assign reqAmp = 14'((32'(scaleValue) * 32'(awmc_pkg::SAMPLE_POS_PEAK)) / 32'(awmc_pkg::SCALE_FULL));

	// Region registers; a write restarts output
	always_ff @(posedge sys_clk) begin
		evenLengthNotice <= 1'b0;
		regionReject <= 1'b0;
		if (!rst_n) begin
			playStart <= awmc_pkg::START_RST;
			playLength <= awmc_pkg::LENGTH_RST;
		end else if (startWrite) begin
			if (startOk) begin
				playStart <= oddStart;
			end else begin
				regionReject <= 1'b1;
			end
		end else if (lengthWrite) begin
			evenLengthNotice <= lengthValue[0];
			if ((evenLen != 22'h000000) && (23'(playStart) + 23'(evenLen) <= 23'(awmc_pkg::ADDR_LAST) + 23'h000001)) begin
				playLength <= evenLen;
			end else begin
				regionReject <= 1'b1;
			end
		end
	end

	// Marker placement, clamped, inside region
	always_ff @(posedge sys_clk) begin
		markReject <= 1'b0;
		if (!rst_n) begin
			markAddr <= awmc_pkg::START_RST;
			markLen <= awmc_pkg::LENGTH_RST;
		end else if (markWrite) begin
			if (markAddrValue >= playStart && markAddrValue <= regionLast) begin
				markAddr <= markAddrValue;
				markLen <= (markLengthValue > awmc_pkg::MARK_LEN_MAX) ? awmc_pkg::MARK_LEN_MAX : markLengthValue;
			end else begin
				markReject <= 1'b1;
			end
		end
	end

	// Marker travels with its sample so a stall keeps them aligned
	assign markHit = markEnable && (playAddr >= markAddr) && (playAddr < markAddr + markLen);

	// Playback address walk; stalls when the output buffer is full
	assign bufPush = (bufCount != 2'b10) && !restart;
	assign bufPop = sampleValid && sampleReady;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			playAddr <= awmc_pkg::START_RST;
		end else if (restart) begin
			playAddr <= (startWrite && startOk) ? oddStart : playStart;
		end else if (bufPush) begin
			playAddr <= (playAddr >= regionLast) ? playStart : playAddr + 22'h000001;
		end
	end

	// Two-entry output buffer, flushed when the region changes
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_entry
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					bufData[gi] <= awmc_pkg::SAMPLE_OFFSET;
					bufMark[gi] <= 1'b0;
				end else if (bufPush && (32'(bufWrPtr) == gi)) begin
					bufData[gi] <= mem[playAddr];
					bufMark[gi] <= markHit;
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (!rst_n || restart) begin
			bufWrPtr <= 1'b0;
			bufRdPtr <= 1'b0;
			bufCount <= 2'b00;
		end else begin
			if (bufPush) begin
				bufWrPtr <= ~bufWrPtr;
			end
			if (bufPop) begin
				bufRdPtr <= ~bufRdPtr;
			end
			bufCount <= bufCount + {1'b0, bufPush} - {1'b0, bufPop};
		end
	end

	assign sampleValid = (bufCount != 2'b00);
	assign sampleData = bufData[bufRdPtr];
	assign sampleMarker = bufMark[bufRdPtr] & sampleValid;

	// Builtin fill length and scale settings
	always_ff @(posedge sys_clk) begin
		fillLengthReject <= 1'b0;
		scaleTooHigh <= 1'b0;
		if (!rst_n) begin
			fillLength <= awmc_pkg::FILL_LEN_RST;
			scale <= awmc_pkg::SCALE_RST;
		end else begin
			if (fillLengthWrite) begin
				unique case (awmc_pkg::awmc_shape_t'(builtinShape))
					awmc_pkg::SHAPE_SINE, awmc_pkg::SHAPE_TRIANGLE: begin
						if (fillLengthValue >= awmc_pkg::SINE_TRI_MIN_LEN && fillLengthValue[1:0] == 2'b00) begin
							fillLength <= fillLengthValue;
						end else begin
							fillLengthReject <= 1'b1;
						end
					end
					awmc_pkg::SHAPE_SQUARE: begin
						if (fillLengthValue >= awmc_pkg::SQUARE_MIN_LEN && !fillLengthValue[0]) begin
							fillLength <= fillLengthValue;
						end else begin
							fillLengthReject <= 1'b1;
						end
					end
					awmc_pkg::SHAPE_NOISE: begin
						if (fillLengthValue >= awmc_pkg::NOISE_MIN_LEN) begin
							fillLength <= fillLengthValue;
						end else begin
							fillLengthReject <= 1'b1;
						end
					end
				endcase
			end
			if (scaleWrite) begin
				// Peak of the shape plus its starting level must stay in range
				if (scaleValue <= awmc_pkg::SCALE_FULL && 15'(reqAmp) + 15'(absVal(fromData)) <= 15'(awmc_pkg::SAMPLE_POS_PEAK)) begin
					scale <= scaleValue;
				end else begin
					scaleTooHigh <= 1'b1;
				end
			end
		end
	end

	// Single write-protect segment; a new one replaces the old
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			writeProtectActive <= 1'b0;
			protLo <= awmc_pkg::ADDR_FIRST;
			protHi <= awmc_pkg::ADDR_FIRST;
		end else if (unprotect) begin
			writeProtectActive <= 1'b0;
		end else if (writeProtectSet) begin
			if (protAll) begin
				writeProtectActive <= 1'b1;
				protLo <= awmc_pkg::ADDR_FIRST;
				protHi <= awmc_pkg::ADDR_LAST;
			end else if (inRange(protFrom) && inRange(protTo) && protFrom <= protTo) begin
				writeProtectActive <= 1'b1;
				protLo <= protFrom;
				protHi <= protTo;
			end
		end
	end

	// Edit engine: arm on execute, run only after a yes
	always_ff @(posedge sys_clk) begin
		opReject <= 1'b0;
		if (!rst_n) begin
			engState <= awmc_pkg::ENG_IDLE;
			engOp <= 2'b00;
			engShape <= 2'b00;
			engNoiseAdd <= 1'b0;
			engAddr <= awmc_pkg::ADDR_FIRST;
			engFirst <= awmc_pkg::ADDR_FIRST;
			engLast <= awmc_pkg::ADDR_FIRST;
			engSrc <= awmc_pkg::ADDR_FIRST;
			engPhase <= 22'h000000;
			engBase <= awmc_pkg::SAMPLE_OFFSET;
			engEnd <= awmc_pkg::SAMPLE_OFFSET;
			engAmp <= 14'h0000;
		end else begin
			unique case (engState)
				awmc_pkg::ENG_IDLE: begin
					if (executeConfirm) begin
						engOp <= opKind;
						engShape <= builtinShape;
						engNoiseAdd <= noiseAdd;
						engBase <= fromData;
						engEnd <= toData;
						engAmp <= 14'((32'(scale) * 32'(awmc_pkg::SAMPLE_POS_PEAK)) / 32'(awmc_pkg::SCALE_FULL));
						engPhase <= 22'h000000;
						engState <= awmc_pkg::ENG_ARMED;
						unique case (awmc_pkg::awmc_op_t'(opKind))
							awmc_pkg::OP_LINE: begin
								engFirst <= opFrom;
								engLast <= opTo;
								if (!inRange(opFrom) || !inRange(opTo) || opFrom > opTo) begin
									engState <= awmc_pkg::ENG_IDLE;
									opReject <= 1'b1;
								end
							end
							awmc_pkg::OP_BUILTIN: begin
								engFirst <= opFrom;
								engLast <= opFrom + fillLength - 22'h000001;
								if (!inRange(opFrom) || opFrom + fillLength - 22'h000001 > awmc_pkg::ADDR_LAST) begin
									engState <= awmc_pkg::ENG_IDLE;
									opReject <= 1'b1;
								end
							end
							awmc_pkg::OP_COPY: begin
								engSrc <= opFrom;
								engFirst <= opTo;
								engLast <= opTo + opLength - 22'h000001;
								if (!inRange(opFrom) || !inRange(opTo) || opLength == 22'h000000 ||
									opFrom + opLength - 22'h000001 > awmc_pkg::ADDR_LAST ||
									opTo + opLength - 22'h000001 > awmc_pkg::ADDR_LAST) begin
									engState <= awmc_pkg::ENG_IDLE;
									opReject <= 1'b1;
								end
							end
							awmc_pkg::OP_CLEAR: begin
								engFirst <= opAll ? awmc_pkg::ADDR_FIRST : opFrom;
								engLast <= opAll ? awmc_pkg::ADDR_LAST : opTo;
								if (!opAll && (!inRange(opFrom) || !inRange(opTo) || opFrom > opTo)) begin
									engState <= awmc_pkg::ENG_IDLE;
									opReject <= 1'b1;
								end
							end
						endcase
					end
				end
				awmc_pkg::ENG_ARMED: begin
					if (confirmNo) begin
						engState <= awmc_pkg::ENG_IDLE;
					end else if (confirmYes) begin
						engAddr <= engFirst;
						engState <= awmc_pkg::ENG_RUN;
					end
				end
				awmc_pkg::ENG_RUN: begin
					engAddr <= engAddr + 22'h000001;
					engSrc <= engSrc + 22'h000001;
					engPhase <= (engPhase == fillLength - 22'h000001) ? 22'h000000 : engPhase + 22'h000001;
					if (engAddr == engLast) begin
						engState <= awmc_pkg::ENG_IDLE;
					end
				end
				default: engState <= awmc_pkg::ENG_IDLE;
			endcase
		end
	end

	assign awaitingConfirm = (engState == awmc_pkg::ENG_ARMED);
	assign busy = (engState != awmc_pkg::ENG_IDLE);

	// Noise source, free running so successive fills differ
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			lfsr <= 16'hace1;
		end else begin
			lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		end
	end

	// Engine value; wide math avoids overflow
	always_comb begin
		longint d, span, y, amp, len, q, h, p, acc;
		d = longint'(engAddr - engFirst);
		span = longint'(engLast - engFirst);
		amp = longint'(engAmp);
		len = longint'(fillLength);
		q = len / 4;
		h = len / 2;
		p = longint'(engPhase);
		y = 0;
		acc = longint'(engBase);
		unique case (awmc_pkg::awmc_op_t'(engOp))
			awmc_pkg::OP_LINE: begin
				if (span != 0) begin
					y = ((longint'(engEnd) - longint'(engBase)) * d) / span;
				end
			end
			awmc_pkg::OP_BUILTIN: begin
				unique case (awmc_pkg::awmc_shape_t'(engShape))
					awmc_pkg::SHAPE_SINE: begin
						// Parabolic half-cycles: cheap and close to a sine
						if (p < h) begin
							y = (4 * amp * p * (h - p)) / (h * h);
						end else begin
							y = -(4 * amp * (p - h) * (len - p)) / (h * h);
						end
					end
					awmc_pkg::SHAPE_TRIANGLE: begin
						if (p < q) begin
							y = (amp * p) / q;
						end else if (p < 3 * q) begin
							y = (amp * (2 * q - p)) / q;
						end else begin
							y = (amp * (p - len)) / q;
						end
					end
					awmc_pkg::SHAPE_SQUARE: begin
						y = (p < h) ? amp : -amp;
					end
					awmc_pkg::SHAPE_NOISE: begin
						y = (longint'($signed(lfsr[13:0])) * amp) / 8192;
						if (engNoiseAdd) begin
							acc = longint'(mem[engAddr]);
						end
					end
				endcase
			end
			awmc_pkg::OP_COPY: begin
				acc = longint'(mem[engSrc]);
			end
			awmc_pkg::OP_CLEAR: begin
				acc = 0;
			end
		endcase
		acc = acc + y;
		// Saturate to the legal sample range
		if (acc > longint'(awmc_pkg::SAMPLE_POS_PEAK)) begin
			acc = longint'(awmc_pkg::SAMPLE_POS_PEAK);
		end else if (acc < longint'(awmc_pkg::SAMPLE_NEG_PEAK)) begin
			acc = longint'(awmc_pkg::SAMPLE_NEG_PEAK);
		end
		engValue = 14'(acc);
	end

	// Write port: engine first, point when idle
	assign pointReject = pointWrite && (busy || !inRange(currentEditAddress) ||
		pointData < awmc_pkg::SAMPLE_NEG_PEAK || pointData > awmc_pkg::SAMPLE_POS_PEAK);
	always_comb begin
		memWe = 1'b0;
		memWa = engAddr;
		memWd = engValue;
		if (engState == awmc_pkg::ENG_RUN) begin
			memWe = 1'b1;
		end else if (pointWrite && !pointReject) begin
			memWe = 1'b1;
			memWa = currentEditAddress;
			memWd = pointData;
		end
		if (writeProtectActive && memWa >= protLo && memWa <= protHi) begin
			memWe = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (memWe) begin
			mem[memWa] <= memWd;
		end
	end

	// Square duty, triangle symmetry and frequency limits
	always_ff @(posedge sys_clk) begin
		settingReject <= 1'b0;
		if (!rst_n) begin
			waveFreq <= awmc_pkg::FREQ_RST;
			squareWaveDuty <= awmc_pkg::DUTY_RST;
			triangleSymmetry <= awmc_pkg::DUTY_RST;
		end else if (freqWrite) begin
			if (waveSel == awmc_pkg::WAVE_SQUARE && (freqValue > awmc_pkg::SQ_FREQ_MAX ||
				(freqValue > awmc_pkg::SQ_WIDE_FREQ_MAX && (squareWaveDuty < awmc_pkg::SQ_DUTY_NARROW_MIN ||
				squareWaveDuty > awmc_pkg::SQ_DUTY_NARROW_MAX)))) begin
				settingReject <= 1'b1;
			end else if (waveSel == awmc_pkg::WAVE_TRIANGLE && freqValue > awmc_pkg::TRI_FREQ_MAX) begin
				settingReject <= 1'b1;
			end else begin
				waveFreq <= freqValue;
			end
		end else if (shapeParamWrite) begin
			if (waveSel == awmc_pkg::WAVE_SQUARE) begin
				if ((waveFreq <= awmc_pkg::SQ_WIDE_FREQ_MAX && shapeParamValue >= awmc_pkg::SQ_DUTY_WIDE_MIN &&
					shapeParamValue <= awmc_pkg::SQ_DUTY_WIDE_MAX) ||
					(shapeParamValue >= awmc_pkg::SQ_DUTY_NARROW_MIN &&
					shapeParamValue <= awmc_pkg::SQ_DUTY_NARROW_MAX)) begin
					squareWaveDuty <= shapeParamValue;
				end else begin
					settingReject <= 1'b1;
				end
			end else if (waveSel == awmc_pkg::WAVE_TRIANGLE) begin
				if (shapeParamValue >= awmc_pkg::TRI_SYM_MIN && shapeParamValue <= awmc_pkg::TRI_SYM_MAX) begin
					triangleSymmetry <= shapeParamValue;
				end else begin
					settingReject <= 1'b1;
				end
			end else begin
				settingReject <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: hdl/awmc_pkg.sv */
package awmc_pkg;
	// Memory geometry
	localparam int ADDR_W = 22;
	localparam int SAMPLE_W = 14;
	localparam logic [21:0] ADDR_FIRST = 22'h000001;
	localparam logic [21:0] ADDR_LAST = 22'h3d0900;
	localparam logic signed [13:0] SAMPLE_POS_PEAK = 14'sh1fff;
	localparam logic signed [13:0] SAMPLE_NEG_PEAK = -14'sh1fff;
	localparam logic signed [13:0] SAMPLE_OFFSET = 14'sh0000;
	localparam logic [21:0] MARK_LEN_MAX = 22'h000fa0;
	localparam logic [6:0] SCALE_FULL = 7'h64;

	// Values after reset
	localparam logic [21:0] START_RST = 22'h000001;
	localparam logic [21:0] LENGTH_RST = 22'h000002;
	localparam logic [21:0] FILL_LEN_RST = 22'h000010;
	localparam logic [6:0] SCALE_RST = 7'h64;
	localparam logic [6:0] DUTY_RST = 7'h32;
	localparam logic [24:0] FREQ_RST = 25'h00003e8;

	// Predefined fill length limits
	localparam logic [21:0] SINE_TRI_MIN_LEN = 22'h000010;
	localparam logic [21:0] SQUARE_MIN_LEN = 22'h000002;
	localparam logic [21:0] NOISE_MIN_LEN = 22'h000010;

	// Square duty and triangle symmetry limits, percent and hertz
	localparam logic [6:0] SQ_DUTY_WIDE_MIN = 7'h14;
	localparam logic [6:0] SQ_DUTY_WIDE_MAX = 7'h50;
	localparam logic [6:0] SQ_DUTY_NARROW_MIN = 7'h28;
	localparam logic [6:0] SQ_DUTY_NARROW_MAX = 7'h3c;
	localparam logic [24:0] SQ_WIDE_FREQ_MAX = 25'h0989680;
	localparam logic [24:0] SQ_FREQ_MAX = 25'h1c9c380;
	localparam logic [6:0] TRI_SYM_MIN = 7'h0a;
	localparam logic [6:0] TRI_SYM_MAX = 7'h5a;
	localparam logic [24:0] TRI_FREQ_MAX = 25'h04c4b40;

	typedef enum logic [1:0] {
		OP_LINE = 2'b00,
		OP_BUILTIN = 2'b01,
		OP_COPY = 2'b10,
		OP_CLEAR = 2'b11
	} awmc_op_t;

	typedef enum logic [1:0] {
		SHAPE_SINE = 2'b00,
		SHAPE_TRIANGLE = 2'b01,
		SHAPE_SQUARE = 2'b10,
		SHAPE_NOISE = 2'b11
	} awmc_shape_t;

	typedef enum logic [1:0] {
		WAVE_SINE = 2'b00,
		WAVE_SQUARE = 2'b01,
		WAVE_TRIANGLE = 2'b10,
		WAVE_ARBITRARY = 2'b11
	} awmc_wave_t;

	typedef enum logic [1:0] {
		ENG_IDLE = 2'b00,
		ENG_ARMED = 2'b01,
		ENG_RUN = 2'b10
	} awmc_eng_t;
endpackage

/* File: test/awmc_core_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module awmc_core_properties (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [21:0] startValue,
	input wire logic startWrite,
	input wire logic [21:0] lengthValue,
	input wire logic lengthWrite,
	input wire logic [21:0] playStart,
	input wire logic regionReject,
	input wire logic evenLengthNotice,
	input wire logic [21:0] currentEditAddress,
	input wire logic signed [13:0] pointData,
	input wire logic pointWrite,
	input wire logic pointReject,
	input wire logic executeConfirm,
	input wire logic confirmYes,
	input wire logic confirmNo,
	input wire logic awaitingConfirm,
	input wire logic opReject,
	input wire logic busy,
	input wire logic unprotect,
	input wire logic writeProtectActive
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// Region entry
	property p_start_odd;
		startWrite && startValue != 22'h000000 |=>
			regionReject || playStart == $past(startValue) - 22'(!$past(startValue[0]));
	endproperty
	a_start_odd: assert property (p_start_odd) else $error("start not rounded to odd");
	property p_len_notice;
		lengthWrite && !startWrite && lengthValue[0] && lengthValue != 22'h000001 |=> evenLengthNotice;
	endproperty
	a_len_notice: assert property (p_len_notice) else $error("odd length without notice");
	// Point limits, same cycle
	property p_pt_addr;
		pointWrite && (currentEditAddress == 22'h000000 || currentEditAddress > awmc_pkg::ADDR_LAST) |-> pointReject;
	endproperty
	a_pt_addr: assert property (p_pt_addr) else $error("bad address accepted");
	property p_pt_data;
		pointWrite && pointData == 14'sh2000 |-> pointReject;
	endproperty
	a_pt_data: assert property (p_pt_data) else $error("bad sample accepted");
	// Confirm handshake and unprotect
	property p_armed;
		executeConfirm && !busy && !awaitingConfirm |=> awaitingConfirm || opReject;
	endproperty
	a_armed: assert property (p_armed) else $error("execute not armed");
	property p_no;
		awaitingConfirm && confirmNo && !confirmYes |=> !awaitingConfirm && !busy;
	endproperty
	a_no: assert property (p_no) else $error("abandon did not idle");
	property p_yes;
		awaitingConfirm && confirmYes && !confirmNo |=> busy;
	endproperty
	a_yes: assert property (p_yes) else $error("confirm did not run");
	property p_unprot;
		unprotect |=> !writeProtectActive;
	endproperty
	a_unprot: assert property (p_unprot) else $error("protection kept");
endmodule
bind awmc_core awmc_core_properties chk (.*);
`default_nettype wire

/* File: test/awmc_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module awmc_sink (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic signed [13:0] sampleData,
	input wire logic sampleMarker,
	input wire logic sampleValid,
	input wire logic slow,
	output logic sampleReady
);
	logic signed [13:0] seen[$];
	logic marks[$];
	logic [1:0] phase = 2'h0;
	initial sampleReady = 1'b0;
	// Slow mode takes one cycle in three, so the buffer backs up
	always @(posedge sys_clk) begin
		if (rst_n && sampleValid && sampleReady) begin
			seen.push_back(sampleData);
			marks.push_back(sampleMarker);
		end
		phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
		sampleReady <= #1 rst_n && (!slow || phase == 2'h0);
	end
endmodule
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic sys_clk = 1'b0;
	logic rst_n, startWrite, lengthWrite, markEnable, markWrite, pointWrite, opAll, executeConfirm, confirmYes;
	logic confirmNo, fillLengthWrite, scaleWrite, noiseAdd, protAll, writeProtectSet, unprotect, freqWrite;
	logic shapeParamWrite, slow, evenLengthNotice, regionReject, markReject, pointReject, opReject, awaitingConfirm;
	logic busy, fillLengthReject, scaleTooHigh, writeProtectActive, settingReject, sampleMarker, sampleValid, sampleReady;
	logic [21:0] startValue, lengthValue, playStart, playLength, markAddrValue, markLengthValue, currentEditAddress;
	logic [21:0] opFrom, opTo, opLength, fillLengthValue, fillLength, protFrom, protTo;
	logic signed [13:0] pointData, fromData, toData, sampleData;
	logic [1:0] opKind, builtinShape, waveSel;
	logic [6:0] scaleValue, shapeParamValue, squareWaveDuty, triangleSymmetry;
	logic [24:0] freqValue, waveFreq;
	int failCount = 0;
	int checked = 0;

	awmc_core dut (.*);
	awmc_sink snk (.sys_clk, .rst_n, .sampleData, .sampleMarker, .sampleValid, .slow, .sampleReady);

	// 50 ns period
	always #25 sys_clk = ~sys_clk;

	task automatic chk(input logic [24:0] got, input logic [24:0] exp);
		checked++;
		if (got !== exp) begin
			failCount++;
			$display("ERROR %0t: saw %h expected %h", $time, got, exp);
		end
	endtask

	// Strobe held for exactly one sampling edge
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(posedge sys_clk);
		#1 s = 1'b0;
	endtask

	task automatic point(input logic [21:0] a, input logic [13:0] d, input logic r);
		currentEditAddress = a;
		pointData = d;
		pointWrite = 1'b1;
		#1 chk(pointReject, r);
		@(posedge sys_clk);
		#1 pointWrite = 0;
		@(posedge sys_clk);
		#1;
	endtask

	// Replay region 1..4 twice, samples and markers
	task automatic play(input logic [55:0] e, input logic [3:0] m);
		int n;
		startValue = 22'h000001;
		pulse(startWrite);
		snk.seen.delete();
		snk.marks.delete();
		n = 0;
		while (snk.seen.size() < 8 && n < 200) begin
			@(posedge sys_clk);
			n++;
		end
		for (int i = 0; i < 8; i++) begin
			chk(snk.seen[i], e[14 * (i % 4) +: 14]);
			chk(snk.marks[i], m[i % 4]);
		end
	endtask

	task automatic run_op(input logic [1:0] k, input logic [21:0] f, input logic [21:0] t, input logic yes);
		int n;
		opKind = k;
		opFrom = f;
		opTo = t;
		pulse(executeConfirm);
		chk(awaitingConfirm, 1'b1);
		if (yes) begin
			pulse(confirmYes);
			chk(busy, 1'b1);
		end else begin
			pulse(confirmNo);
			chk(busy | awaitingConfirm, 1'b0);
		end
		n = 0;
		while (busy !== 1'b0 && n < 100) begin
			@(posedge sys_clk);
			#1 n++;
		end
		chk(busy, 1'b0);
	endtask

	task automatic test_region();
		chk(playLength, 22'h000002);
		startValue = 22'h0007d0;
		pulse(startWrite);
		chk(playStart, 22'h0007cf);
		lengthValue = 22'h0003e9;
		pulse(lengthWrite);
		chk(evenLengthNotice, 1'b1);
		chk(playLength, 22'h0003e8);
		startValue = 22'h3d0901;
		pulse(startWrite);
		chk(regionReject, 1'b1);
		lengthValue = 22'h000004;
		pulse(lengthWrite);
		startValue = 22'h000001;
		pulse(startWrite);
		markAddrValue = 22'h000003;
		markLengthValue = 22'h000001;
		pulse(markWrite);
		chk(markReject, 1'b0);
	endtask

	task automatic test_point();
		run_op(awmc_pkg::OP_CLEAR, 22'h000001, 22'h000010, 1'b1);
		point(22'h000003, 14'h0064, 1'b0);
		point(22'h000000, 14'h0001, 1'b1);
		point(22'h3d0901, 14'h0001, 1'b1);
		point(22'h3d0900, 14'h1fff, 1'b0);
		point(22'h000002, 14'h2000, 1'b1);
		slow = 1'b1;
		play({14'h0000, 14'h0064, 14'h0000, 14'h0000}, 4'b0100);
		slow = 1'b0;
	endtask

	task automatic test_protect();
		protFrom = 22'h000003;
		protTo = 22'h000003;
		pulse(writeProtectSet);
		chk(writeProtectActive, 1'b1);
		point(22'h000003, 14'h0005, 1'b0);
		run_op(awmc_pkg::OP_CLEAR, 22'h000003, 22'h000003, 1'b1);
		play({14'h0000, 14'h0064, 14'h0000, 14'h0000}, 4'b0100);
		protFrom = 22'h000004;
		protTo = 22'h000004;
		pulse(writeProtectSet);
		point(22'h000003, 14'h0007, 1'b0);
		point(22'h000004, 14'h0009, 1'b0);
		play({14'h0000, 14'h0007, 14'h0000, 14'h0000}, 4'b0100);
		pulse(unprotect);
		chk(writeProtectActive, 1'b0);
		point(22'h000004, 14'h0009, 1'b0);
		play({14'h0009, 14'h0007, 14'h0000, 14'h0000}, 4'b0100);
	endtask

	task automatic test_ops();
		fromData = 14'h0000;
		toData = 14'h012c;
		run_op(awmc_pkg::OP_LINE, 22'h000001, 22'h000004, 1'b0);
		play({14'h0009, 14'h0007, 14'h0000, 14'h0000}, 4'b0100);
		run_op(awmc_pkg::OP_LINE, 22'h000001, 22'h000004, 1'b1);
		play({14'h012c, 14'h00c8, 14'h0064, 14'h0000}, 4'b0100);
		opLength = 22'h000002;
		run_op(awmc_pkg::OP_COPY, 22'h000001, 22'h000003, 1'b1);
		play({14'h0064, 14'h0000, 14'h0064, 14'h0000}, 4'b0100);
		run_op(awmc_pkg::OP_CLEAR, 22'h000002, 22'h000003, 1'b1);
		play({14'h0064, 14'h0000, 14'h0000, 14'h0000}, 4'b0100);
	endtask

	task automatic test_settings();
		waveSel = 2'h2;
		freqValue = 25'h04c4b41;
		pulse(freqWrite);
		chk(settingReject, 1'b1);
		freqValue = 25'h04c4b40;
		pulse(freqWrite);
		chk(waveFreq, 25'h04c4b40);
		shapeParamValue = 7'h09;
		pulse(shapeParamWrite);
		chk(settingReject, 1'b1);
		waveSel = 2'h1;
		freqValue = 25'h0989680;
		pulse(freqWrite);
		shapeParamValue = 7'h14;
		pulse(shapeParamWrite);
		chk(squareWaveDuty, 7'h14);
		freqValue = 25'h0989681;
		pulse(freqWrite);
		chk(settingReject, 1'b1);
		fillLengthValue = 22'h000012;
		pulse(fillLengthWrite);
		chk(fillLengthReject, 1'b1);
		chk(fillLength, 22'h000010);
		builtinShape = 2'h2;
		fillLengthValue = 22'h000002;
		pulse(fillLengthWrite);
		chk(fillLength, 22'h000002);
		scaleValue = 7'h65;
		pulse(scaleWrite);
		chk(scaleTooHigh, 1'b1);
	endtask

	task automatic completeRun();
		$display("comparisons %0d mismatches %0d", checked, failCount);
		if (failCount == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{rst_n, startWrite, lengthWrite, markWrite, pointWrite, opAll, executeConfirm, confirmYes, confirmNo} = '0;
		{fillLengthWrite, scaleWrite, noiseAdd, protAll, writeProtectSet, unprotect, freqWrite, shapeParamWrite} = '0;
		{startValue, lengthValue, markAddrValue, markLengthValue, currentEditAddress, opFrom, opTo, opLength} = '0;
		{fillLengthValue, protFrom, protTo, pointData, fromData, toData, opKind, builtinShape} = '0;
		{scaleValue, shapeParamValue, freqValue, slow} = '0;
		markEnable = 1'b1;
		waveSel = 2'h3;
		repeat (20) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		test_region();
		test_point();
		test_protect();
		test_ops();
		test_settings();
		completeRun();
	end

	// Hang guard, far past the run
	initial begin
		repeat (20000) @(posedge sys_clk);
		failCount++;
		completeRun();
	end
endmodule
`default_nettype wire
